// >>> instruction_control.v
// main control: instruction word, decode, address modify, sequencing
// assumes memory and arithmetic section sit on mclk with a ready handshake
`timescale 1ns/1ps
`include "instruction_control_regs.vh"

module instruction_control (
    // clock and reset
    input  wire        mclk,
    input  wire        sys_rst,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // storage side
    output reg         mem_req_ff,
    output reg         mem_bank_ff,
    output reg  [13:0] storage_address_reg_one_ff,
    output reg  [13:0] storage_address_reg_two_ff,
    input  wire        mem_ack,
    input  wire [47:0] mem_rdata,
    // arithmetic section
    output reg         cmd_valid_ff,
    output reg  [5:0]  cmd_op_ff,
    output reg  [2:0]  cmd_desig_ff,
    output reg  [14:0] cmd_operand_ff,
    output reg         shift_step_ff,
    output reg  [2:0]  chan_sel_ff,
    output reg  [2:0]  equip_sel_ff,
    output reg  [8:0]  mode_sel_ff,
    input  wire        arith_done,
    input  wire        jump_cond,
    input  wire [10:0] exp_in
);

    // one-hot sequence states
    localparam [9:0] S_IDLE  = 10'h001;
    localparam [9:0] S_FETCH = 10'h002;
    localparam [9:0] S_DEC   = 10'h004;
    localparam [9:0] S_XFER  = 10'h008;
    localparam [9:0] S_MOD   = 10'h010;
    localparam [9:0] S_IND   = 10'h020;
    localparam [9:0] S_EXEC  = 10'h040;
    localparam [9:0] S_STEP  = 10'h080;
    localparam [9:0] S_NEXT  = 10'h100;
    localparam [9:0] S_HALT  = 10'h200;

    // additive add: one's complement with end-around carry
    function [14:0] oc_add;
        input [14:0] a;
        input [14:0] b;
        reg   [15:0] s;
        begin
            s = {1'b0, a} + {1'b0, b};
            oc_add = s[14:0] + {14'h0000, s[15]};
        end
    endfunction

    // storage address into the bank register chosen by the low bit
    function [13:0] bank_addr;
        input [14:0] a;
        begin
            bank_addr = a[14:1];
        end
    endfunction

    reg [47:0] instruction_word_register_ff;
    reg [14:0] address_accumulator_ff;
    reg [14:0] abuf_ff;
    reg [14:0] paddr_ff;
    reg [14:0] index_ff [1:6];
    reg [9:0]  state_ff;
    reg        lower_ff;
    reg        fault_ff;
    reg        exp_phase_ff;
    integer    i;

    // opcode and designator decode of the upper half
    wire [5:0]  op   = instruction_word_register_ff[`F_MSB:`F_LSB];
    wire [2:0]  desig = instruction_word_register_ff[`B_MSB:`B_LSB];
    wire [14:0] m_field = instruction_word_register_ff[`M_MSB:`M_LSB];
    wire is_fault  = (op == `OP_FAULT_LO) || (op == `OP_FAULT_HI);
    wire is_muldiv = (op == `OP_MUL) || (op == `OP_DIV);
    wire is_fp     = (op >= `OP_FP_LSB) && (op <= `OP_FP_MSB);
    wire is_search = (op >= `OP_SEARCH_LO) && (op <= `OP_SEARCH_HI);
    wire is_jump   = (op == `OP_A_JUMP);
    wire is_extf   = (op == `OP_EXT_FUNC);
    wire is_imm    = (op == `OP_ENTER_Q) || (op == `OP_ENTER_A) ||
                     (op == `OP_INC_A);
    // designator read as index only where opcode uses it that way
    wire b_index   = !is_jump && !is_extf;
    wire b_sel     = b_index && (desig != `B_NONE) &&
                     (desig != `B_INDIRECT);
    wire b_ind     = b_index && (desig == `B_INDIRECT);
    wire [14:0] idx_val = b_sel ? index_ff[desig] : `RST_ADDR;

    // apb decode
    wire apb_acc = psel && penable;
    wire apb_wr  = apb_acc && pwrite && pready;
    wire [2:0] ctl_idx = pwdata[`CTRL_IDX_MSB:`CTRL_IDX_LSB];
    wire ctl_ok  = (ctl_idx != 3'h0) && (ctl_idx != 3'h7);
    wire wr_ctrl = apb_wr && (paddr == `OFS_CTRL);
    wire start   = wr_ctrl && pwdata[`CTRL_START];
    wire busy    = !(state_ff == S_IDLE || state_ff == S_HALT);
    wire mapped  = (paddr <= `OFS_INDEX) && (paddr[1:0] == 2'h0);

    // apb answer: ready one cycle into the access phase
    always @(posedge mclk) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= apb_acc && !pready;
            pslverr <= apb_acc && !pready && !mapped;
            prdata  <= 32'h00000000;
            if (apb_acc && !pready && !pwrite) begin
                case (paddr)
                    `OFS_STATUS: prdata <= {14'h0000, state_ff, 5'h00,
                        lower_ff, fault_ff, busy};
                    `OFS_PADDR:   prdata <= {17'h00000, paddr_ff};
                    `OFS_WORD_LO: prdata <= {8'h00,
                        instruction_word_register_ff[23:0]};
                    `OFS_WORD_HI: prdata <= {8'h00,
                        instruction_word_register_ff[47:24]};
                    `OFS_ACC:  prdata <= {17'h00000, address_accumulator_ff};
                    `OFS_ABUF: prdata <= {17'h00000, abuf_ff};
                    default:   prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // sequencer and datapath; one command per transfer per state
    always @(posedge mclk) begin
        if (sys_rst) begin
            state_ff <= S_IDLE;
            instruction_word_register_ff <= `RST_WORD;
            address_accumulator_ff <= `RST_ADDR;
            abuf_ff <= `RST_ADDR;
            paddr_ff <= `RST_ADDR;
            lower_ff <= 1'b0;
            fault_ff <= 1'b0;
            exp_phase_ff <= 1'b0;
            mem_req_ff <= 1'b0;
            mem_bank_ff <= 1'b0;
            storage_address_reg_one_ff <= 14'h0000;
            storage_address_reg_two_ff <= 14'h0000;
            cmd_valid_ff <= 1'b0;
            cmd_op_ff <= 6'h00;
            cmd_desig_ff <= 3'h0;
            cmd_operand_ff <= `RST_ADDR;
            shift_step_ff <= 1'b0;
            chan_sel_ff <= 3'h0;
            equip_sel_ff <= 3'h0;
            mode_sel_ff <= 9'h000;
            for (i = 1; i <= 6; i = i + 1)
                index_ff[i] <= `RST_ADDR;
        end else begin
            cmd_valid_ff <= 1'b0;
            shift_step_ff <= 1'b0;
            // software access while stopped; index only via buffer
            if (!busy && apb_wr) begin
                if (paddr == `OFS_PADDR)
                    paddr_ff <= pwdata[14:0];
                if (paddr == `OFS_ABUF)
                    abuf_ff <= pwdata[14:0];
                if (wr_ctrl && pwdata[`CTRL_LD_IDX] && ctl_ok)
                    index_ff[ctl_idx] <= abuf_ff;
                if (wr_ctrl && pwdata[`CTRL_RD_IDX] && ctl_ok)
                    abuf_ff <= index_ff[ctl_idx];
                if (paddr == `OFS_STATUS && pwdata[`ST_FAULT])
                    fault_ff <= 1'b0;
            end
            case (state_ff)
                S_IDLE, S_HALT: begin
                    // stopped: nothing issued until start
                    if (start) begin
                        state_ff <= S_FETCH;
                        mem_req_ff <= 1'b1;
                        mem_bank_ff <= paddr_ff[0];
                        if (paddr_ff[0])
                            storage_address_reg_two_ff <= bank_addr(paddr_ff);
                        else
                            storage_address_reg_one_ff <= bank_addr(paddr_ff);
                    end
                end
                S_FETCH: begin
                    // whole word kept for both halves
                    if (mem_ack) begin
                        mem_req_ff <= 1'b0;
                        instruction_word_register_ff <= mem_rdata;
                        lower_ff <= 1'b0;
                        state_ff <= S_DEC;
                    end
                end
                S_DEC: begin
                    if (is_fault) begin
                        fault_ff <= 1'b1;
                        state_ff <= S_HALT;
                    end else begin
                        // selected index goes to buffer first
                        if (b_sel)
                            abuf_ff <= idx_val;
                        state_ff <= S_XFER;
                    end
                end
                S_XFER: begin
                    // address copied for every instruction except a fault code
                    address_accumulator_ff <= m_field;
                    if (b_sel && (abuf_ff != `RST_ADDR))
                        state_ff <= S_MOD;
                    else if (b_ind) begin
                        state_ff <= S_IND;
                        mem_req_ff <= 1'b1;
                        mem_bank_ff <= m_field[0];
                        if (m_field[0])
                            storage_address_reg_two_ff <= bank_addr(m_field);
                        else
                            storage_address_reg_one_ff <= bank_addr(m_field);
                    end else
                        state_ff <= S_EXEC;
                end
                S_MOD: begin
                    address_accumulator_ff <=
                        oc_add(address_accumulator_ff, abuf_ff);
                    state_ff <= S_EXEC;
                end
                S_IND: begin
                    // one level: low address of fetched word
                    if (mem_ack) begin
                        mem_req_ff <= 1'b0;
                        address_accumulator_ff <= mem_rdata[14:0];
                        state_ff <= S_EXEC;
                    end
                end
                S_EXEC: begin
                    cmd_valid_ff <= 1'b1;
                    cmd_op_ff <= op;
                    cmd_desig_ff <= desig;
                    cmd_operand_ff <= address_accumulator_ff;
                    if (is_extf) begin
                        chan_sel_ff  <= m_field[14:12];
                        equip_sel_ff <= m_field[11:9];
                        mode_sel_ff  <= m_field[8:0];
                        state_ff <= S_NEXT;
                    end else if (is_jump) begin
                        if (jump_cond) begin
                            paddr_ff <= m_field;
                            state_ff <= S_FETCH;
                            mem_req_ff <= 1'b1;
                            mem_bank_ff <= m_field[0];
                            if (m_field[0])
                                storage_address_reg_two_ff <=
                                    bank_addr(m_field);
                            else
                                storage_address_reg_one_ff <=
                                    bank_addr(m_field);
                        end else
                            state_ff <= S_NEXT;
                    end else if (is_muldiv) begin
                        abuf_ff <= `MULDIV_STEPS;
                        state_ff <= S_STEP;
                    end else if (is_fp) begin
                        // exponents: own in accumulator, other in buffer
                        address_accumulator_ff <=
                            {{4{exp_in[10]}}, exp_in};
                        abuf_ff <= {{4{m_field[10]}}, m_field[10:0]};
                        exp_phase_ff <= 1'b1;
                        state_ff <= S_STEP;
                    end else if (is_imm || is_search) begin
                        state_ff <= S_STEP; // value handed as operand
                    end else begin
                        // operand from storage via a bank address register
                        mem_bank_ff <= address_accumulator_ff[0];
                        if (address_accumulator_ff[0])
                            storage_address_reg_two_ff <=
                                bank_addr(address_accumulator_ff);
                        else
                            storage_address_reg_one_ff <=
                                bank_addr(address_accumulator_ff);
                        state_ff <= S_STEP;
                    end
                end
                S_STEP: begin
                    if (is_muldiv) begin
                        // one shift per step until count is spent
                        if (abuf_ff == `RST_ADDR)
                            state_ff <= S_NEXT;
                        else begin
                            shift_step_ff <= 1'b1;
                            abuf_ff <= abuf_ff - 15'h0001;
                        end
                    end else if (exp_phase_ff) begin
                        address_accumulator_ff <=
                            oc_add(address_accumulator_ff, abuf_ff);
                        exp_phase_ff <= 1'b0;
                    end else if (arith_done)
                        state_ff <= S_NEXT;
                end
                S_NEXT: begin
                    if (!lower_ff) begin
                        // half exit: lower instruction moves up
                        instruction_word_register_ff <=
                            {instruction_word_register_ff[23:0],
                             24'h000000};
                        lower_ff <= 1'b1;
                        state_ff <= S_DEC;
                    end else begin
                        paddr_ff <= paddr_ff + 15'h0001;
                        mem_req_ff <= 1'b1;
                        mem_bank_ff <= ~paddr_ff[0];
                        if (!paddr_ff[0])
                            storage_address_reg_two_ff <=
                                bank_addr(paddr_ff + 15'h0001);
                        else
                            storage_address_reg_one_ff <=
                                bank_addr(paddr_ff + 15'h0001);
                        state_ff <= S_FETCH;
                    end
                end
                default: state_ff <= S_IDLE;
            endcase
            // a fault raised this cycle is kept over a clear
            if (state_ff == S_DEC && is_fault)
                fault_ff <= 1'b1;
        end
    end

endmodule

// >>> instruction_control_regs.vh
// register map, field positions and code values for instruction_control
// assumes a 32-bit apb slave with word-aligned registers
`ifndef INSTRUCTION_CONTROL_REGS_VH
`define INSTRUCTION_CONTROL_REGS_VH

// register byte offsets
`define OFS_CTRL      8'h00
`define OFS_STATUS    8'h04
`define OFS_PADDR     8'h08
`define OFS_WORD_LO   8'h0C
`define OFS_WORD_HI   8'h10
`define OFS_ACC       8'h14
`define OFS_ABUF      8'h18
`define OFS_INDEX     8'h1C

// control register fields
`define CTRL_START    0
`define CTRL_LD_IDX   1
`define CTRL_RD_IDX   2
`define CTRL_IDX_LSB  4
`define CTRL_IDX_MSB  6

// status register fields
`define ST_RUN        0
`define ST_FAULT      1
`define ST_LOWER      2
`define ST_STATE_LSB  8

// instruction word layout, upper half
`define F_MSB         47
`define F_LSB         42
`define B_MSB         41
`define B_LSB         39
`define M_MSB         38
`define M_LSB         24

// operation codes
`define OP_FAULT_LO   6'h00
`define OP_FAULT_HI   6'h3F
`define OP_ENTER_Q    6'h04
`define OP_ENTER_A    6'h08
`define OP_INC_A      6'h09
`define OP_ADD        6'h0C
`define OP_A_JUMP     6'h12
`define OP_MUL        6'h14
`define OP_DIV        6'h15
`define OP_FP_LSB     6'h18
`define OP_FP_MSB     6'h1B
`define OP_SEARCH_LO  6'h34
`define OP_SEARCH_HI  6'h37
`define OP_EXT_FUNC   6'h3C

// designator values
`define B_NONE        3'h0
`define B_INDIRECT    3'h7

// step count of a multiply or divide
`define MULDIV_STEPS  15'h0030

// reset values
`define RST_WORD      48'h000000000000
`define RST_ADDR      15'h0000

`endif

// >>> instruction_control_asserts.sv
// port checker for instruction_control: apb, storage and command timing
// assumes binding onto the design top and the register header on the path
`timescale 1ns/1ps
`include "instruction_control_regs.vh"
module instruction_control_asserts (
    // clock and reset
    input wire        mclk,
    input wire        sys_rst,
    // apb
    input wire        psel,
    input wire        penable,
    input wire        pready,
    input wire        pslverr,
    // storage
    input wire        mem_req_ff,
    input wire        mem_bank_ff,
    input wire [13:0] storage_address_reg_one_ff,
    input wire [13:0] storage_address_reg_two_ff,
    input wire        mem_ack,
    // commands
    input wire        cmd_valid_ff,
    input wire [5:0]  cmd_op_ff,
    input wire        shift_step_ff
);
    reg [6:0] steps_ff;

    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // counts multiply/divide steps since the last command
    always @(posedge mclk) begin
        if (sys_rst || cmd_valid_ff)
            steps_ff <= 7'h00;
        else if (shift_step_ff)
            steps_ff <= steps_ff + 7'h01;
    end

    chk_fault_not_run: assert property (cmd_valid_ff |->
        cmd_op_ff != `OP_FAULT_LO && cmd_op_ff != `OP_FAULT_HI)
        else $error("fault code issued as a command");
    chk_step_muldiv: assert property (shift_step_ff |->
        (cmd_op_ff == `OP_MUL || cmd_op_ff == `OP_DIV))
        else $error("step pulse outside multiply or divide");
    chk_step_total: assert property (cmd_valid_ff && steps_ff != 7'h00
        |-> steps_ff == `MULDIV_STEPS)
        else $error("step count of multiply or divide wrong");
    chk_step_limit: assert property (steps_ff <= `MULDIV_STEPS)
        else $error("too many step pulses");
    chk_cmd_single: assert property (cmd_valid_ff |=> !cmd_valid_ff)
        else $error("command pulse longer than one cycle");
    chk_req_holds: assert property (mem_req_ff && !mem_ack |=>
        mem_req_ff && $stable(mem_bank_ff)
        && $stable(storage_address_reg_one_ff)
        && $stable(storage_address_reg_two_ff))
        else $error("storage request changed before ack");
    chk_req_ends: assert property (mem_req_ff && mem_ack |=> !mem_req_ff)
        else $error("storage request kept after ack");
    chk_fetch_quiet: assert property (cmd_valid_ff |->
        !$past(mem_req_ff))
        else $error("command issued while storage busy");
    chk_apb_wait: assert property ($rose(penable) && psel |->
        !pready ##1 (pready && penable))
        else $error("apb answer not after one wait state");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("slave error without ready");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_reset_quiet: assert property (disable iff (1'b0) sys_rst |=>
        !mem_req_ff && !cmd_valid_ff && !pready)
        else $error("outputs active after reset");
endmodule

bind instruction_control instruction_control_asserts u_chk (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .mem_req_ff(mem_req_ff),
    .mem_bank_ff(mem_bank_ff),
    .storage_address_reg_one_ff(storage_address_reg_one_ff),
    .storage_address_reg_two_ff(storage_address_reg_two_ff),
    .mem_ack(mem_ack), .cmd_valid_ff(cmd_valid_ff),
    .cmd_op_ff(cmd_op_ff), .shift_step_ff(shift_step_ff));

// >>> storage_arith_model.sv
// far side model: core storage with alternating latency, arithmetic done
// assumes the bench preloads mem; unused words read as fault code 00
`timescale 1ns/1ps
module storage_arith_model (
    // clock and reset
    input  wire        mclk,
    input  wire        sys_rst,
    // storage
    input  wire        mem_req_ff,
    input  wire        mem_bank_ff,
    input  wire [13:0] sreg_one,
    input  wire [13:0] sreg_two,
    output reg         mem_ack,
    output reg  [47:0] mem_rdata,
    // arithmetic
    input  wire        cmd_valid_ff,
    output reg         arith_done
);
    reg  [47:0] mem [0:255];
    reg  [2:0]  cnt, acnt;
    reg         slow, apend;
    integer     i;
    // bank bit picks the register; it is also the low address bit
    wire [14:0] req_addr = {mem_bank_ff ? sreg_two : sreg_one, mem_bank_ff};

    initial begin
        for (i = 0; i < 256; i = i + 1)
            mem[i] = 48'h000000000000;
        mem_ack = 1'b0;
        arith_done = 1'b0;
        mem_rdata = 48'h5A5A5A5A5A5A;
    end

    // storage answers fast and slow in turn; data toggles when released
    always @(posedge mclk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (sys_rst) begin
            cnt <= 3'h0;
            slow <= 1'b0;
        end else if (mem_req_ff && !mem_ack) begin
            if (cnt == (slow ? 3'h3 : 3'h0)) begin
                mem_ack <= 1'b1;
                mem_rdata <= mem[req_addr[7:0]];
                cnt <= 3'h0;
                slow <= ~slow;
            end else
                cnt <= cnt + 3'h1;
        end
    end

    // arithmetic completion three cycles after each command
    always @(posedge mclk) begin
        arith_done <= 1'b0;
        if (sys_rst) begin
            apend <= 1'b0;
            acnt <= 3'h0;
        end else if (cmd_valid_ff) begin
            apend <= 1'b1;
            acnt <= 3'h0;
        end else if (apend) begin
            acnt <= acnt + 3'h1;
            if (acnt == 3'h1) begin
                arith_done <= 1'b1;
                apend <= 1'b0;
            end
        end
    end
endmodule

// >>> instruction_control_test.sv
// bench for instruction_control: registers over apb, programs in storage
// assumes storage_arith_model as far side and the bound port checker
`timescale 1ns/1ps
`include "instruction_control_regs.vh"
module instruction_control_test;
    reg         mclk, sys_rst, psel, penable, pwrite, jump_cond;
    reg  [7:0]  paddr;
    reg  [31:0] pwdata, rd;
    reg  [10:0] exp_in;
    reg         er;
    wire [31:0] prdata;
    wire        pready, pslverr, mem_req_ff, mem_bank_ff, mem_ack;
    wire        cmd_valid_ff, shift_step_ff, arith_done;
    wire [13:0] sa1, sa2;
    wire [47:0] mem_rdata;
    wire [5:0]  cmd_op_ff;
    wire [2:0]  cmd_desig_ff, chan_sel_ff, equip_sel_ff;
    wire [14:0] cmd_operand_ff;
    wire [8:0]  mode_sel_ff;
    integer     fails, total_checks, steps, n;
    reg  [23:0] ops[$];
    reg  [14:0] fetch[$];

    instruction_control u_dut (.mclk(mclk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_req_ff(mem_req_ff),
        .mem_bank_ff(mem_bank_ff), .storage_address_reg_one_ff(sa1),
        .storage_address_reg_two_ff(sa2), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .cmd_valid_ff(cmd_valid_ff),
        .cmd_op_ff(cmd_op_ff), .cmd_desig_ff(cmd_desig_ff),
        .cmd_operand_ff(cmd_operand_ff), .shift_step_ff(shift_step_ff),
        .chan_sel_ff(chan_sel_ff), .equip_sel_ff(equip_sel_ff),
        .mode_sel_ff(mode_sel_ff), .arith_done(arith_done),
        .jump_cond(jump_cond), .exp_in(exp_in));
    storage_arith_model u_far (.mclk(mclk), .sys_rst(sys_rst),
        .mem_req_ff(mem_req_ff), .mem_bank_ff(mem_bank_ff),
        .sreg_one(sa1), .sreg_two(sa2), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .cmd_valid_ff(cmd_valid_ff),
        .arith_done(arith_done));

    // clock and watchdog
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        fails = fails + 1;
        conclude;
    end

    // records commands, steps and storage addresses taken
    always @(posedge mclk) begin
        if (cmd_valid_ff === 1'b1)
            ops.push_back({cmd_op_ff, cmd_desig_ff, cmd_operand_ff});
        if (shift_step_ff === 1'b1)
            steps = steps + 1;
        if (mem_req_ff === 1'b1 && mem_ack === 1'b1)
            fetch.push_back(u_far.req_addr);
    end

    task check(input logic [47:0] got, input logic [47:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task conclude;
        begin
            if (fails == 0 && total_checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask

    task apb(input logic w_en, input logic [7:0] a, input logic [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= w_en;
            paddr <= a;
            pwdata <= d;
            @(posedge mclk);
            penable <= 1'b1;
            @(posedge mclk);
            while (pready !== 1'b1)
                @(posedge mclk);
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge mclk);
        end
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] exp, input logic e);
        begin
            apb(1'b0, a, 32'h00000000);
            check(er, e);
            if (!e)
                check(rd, exp);
        end
    endtask

    function [47:0] w(input [5:0] f1, input [2:0] b1, input [14:0] m1,
                      input [5:0] f2, input [2:0] b2, input [14:0] m2);
        w = {f1, b1, m1, f2, b2, m2};
    endfunction

    // starts at pa and waits for the halt on a fault code
    task run(input logic [14:0] pa);
        begin
            ops.delete();
            fetch.delete();
            steps = 0;
            apb(1'b1, `OFS_PADDR, {17'h00000, pa});
            apb(1'b1, `OFS_CTRL, 32'h00000001);
            n = 0;
            rd = 32'h00000000;
            while (rd[1] !== 1'b1 && n < 100) begin
                apb(1'b0, `OFS_STATUS, 32'h00000000);
                n = n + 1;
            end
            check(rd[1:0], 2'h2);
            n = fetch.size();
            repeat (10) @(posedge mclk);
            check(fetch.size(), n);
            apb(1'b1, `OFS_STATUS, 32'h00000002);
        end
    endtask

    task t_regs;
        begin
            rdc(`OFS_STATUS, 32'h00000100, 1'b0);
            rdc(`OFS_ACC, 32'h00000000, 1'b0);
            rdc(`OFS_WORD_HI, 32'h00000000, 1'b0);
            apb(1'b1, `OFS_WORD_HI, 32'h00FFFFFF);
            rdc(`OFS_WORD_HI, 32'h00000000, 1'b0);
            rdc(8'h20, 32'h00000000, 1'b1);
            rdc(`OFS_INDEX, 32'h00000000, 1'b0);
            apb(1'b1, `OFS_PADDR, 32'h00007FFF);
            rdc(`OFS_PADDR, 32'h00007FFF, 1'b0);
            apb(1'b1, `OFS_ABUF, 32'h00000005);
            apb(1'b1, `OFS_CTRL, 32'h00000032);
            apb(1'b1, `OFS_ABUF, 32'h00000000);
            apb(1'b1, `OFS_CTRL, 32'h00000034);
            rdc(`OFS_ABUF, 32'h00000005, 1'b0);
        end
    endtask

    task t_modify;
        begin
            u_far.mem[8'h10] = w(`OP_ADD, 3'h3, 15'h0100,
                                 `OP_ADD, 3'h2, 15'h0200);
            run(15'h0010);
            check(ops.size(), 2);
            check(ops[0], {`OP_ADD, 3'h3, 15'h0105});
            check(ops[1], {`OP_ADD, 3'h2, 15'h0200});
            check(fetch[1], 15'h0011);
        end
    endtask

    task t_muldiv;
        begin
            u_far.mem[8'h20] = w(`OP_MUL, 3'h0, 15'h0007,
                                 `OP_DIV, 3'h0, 15'h0009);
            u_far.mem[8'h21] = w(`OP_FAULT_HI, 3'h0, 15'h0000,
                                 `OP_ADD, 3'h0, 15'h0000);
            run(15'h0020);
            check(steps, 2 * `MULDIV_STEPS);
            check(ops[1][23:18], `OP_DIV);
            check(ops.size(), 2);
        end
    endtask

    task t_extfunc;
        begin
            u_far.mem[8'h30] = w(`OP_EXT_FUNC, 3'h0, 15'h561F,
                                 `OP_ENTER_Q, 3'h0, 15'h1234);
            u_far.mem[8'h31] = {`OP_FP_LSB, 18'h00003, 24'h000000};
            run(15'h0030);
            check({chan_sel_ff, equip_sel_ff, mode_sel_ff}, 15'h561F);
            check(ops[1], {`OP_ENTER_Q, 3'h0, 15'h1234});
            rdc(`OFS_ACC, 32'h00000008, 1'b0);
        end
    endtask

    task t_indirect_jump;
        begin
            jump_cond <= 1'b1;
            u_far.mem[8'h40] = w(`OP_ADD, 3'h7, 15'h0050,
                                 `OP_A_JUMP, 3'h0, 15'h0060);
            u_far.mem[8'h50] = 48'h000000002222;
            run(15'h0040);
            check(fetch[1], 15'h0050);
            check(ops[0], {`OP_ADD, 3'h7, 15'h2222});
            check(fetch[2], 15'h0060);
        end
    endtask

    // reset then the scenarios in turn
    initial begin
        fails = 0;
        total_checks = 0;
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        jump_cond = 1'b0;
        exp_in = 11'h005;
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        t_regs;
        t_modify;
        t_muldiv;
        t_extfunc;
        t_indirect_jump;
        conclude;
    end
endmodule
